// file: hw/dcdsx_core.sv
// converter drive latch, overvoltage protection and drive phasing
// Behaviour
// - with trigger source 0 the latch is set a fixed delay after mid-flyback, edge select ignored.
// - with trigger source 1 and edge select 0 the latch is set on the line drive falling edge.
// - with trigger source 1 and edge select 1 the latch is set on the line drive rising edge.
// - a set starts a short monostable pulse and the output turns on when it ends.
// - current-limit or regulation trip, ORed, resets the latch.
// - the polarity bit inverts the converter drive output.
// - overvoltage held for two lines inhibits both drive outputs.
// - an overvoltage detection sets the readable alarm flag.
// - alarm and inhibit stay latched until low supply or the alarm-clear bit.
// - line drive turns on before and off after the converter drive.
// - a control bit enables sidepin frequency tracking, off after reset.
// - a control bit selects the dynamic correction parabola polarity.
// - a vertical offset toggles each frame with software-set amplitude.
// - line drive is held high while the phasing is off, or while the alarm is set and the all-on phase has ended.
// - soft-start runs at every line drive switch-on, also after alarm clear; soft-stop runs only when leaving the all-on phase.
`timescale 1ns/1ps
`default_nettype none
`include "dcdsx_map.svh"
module dcdsx_core
  import dcdsx_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  input wire logic flybackMid,
  input wire logic lineDriveRaw,
  input wire logic lineStart,
  input wire logic frameStart,
  input wire logic currentTrip,
  input wire logic regulationTrip,
  input wire logic overvoltage_sense_in,
  input wire logic lowSupply,
  output logic converter_drive_out,
  output logic line_drive_out,
  output logic softRampActive,
  output logic sidepin_freq_tracking_enable,
  output logic dyn_correction_polarity,
  output logic [7:0] verticalOffset,
  output logic irq
);
  dcdsx_word_t ctrl;
  dcdsx_word_t vertical_jitter_amplitude;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic lineDrivePrev;
  logic [7:0] trigDelayCnt;
  logic trigDelayRun;
  logic [7:0] monoCnt;
  logic monoRun;
  logic latchOn;
  logic [1:0] ovLines;
  logic overvoltage_alarm_flag;
  logic frameToggle;
  dcdsx_phase_e phase;
  logic [15:0] phaseCnt;
  logic setEvent;
  logic resetCond;
  logic alarmClear;
  logic runWanted;
  logic lineOn;
  logic convOn;
  logic writeCtrl;
  logic writeIrq;
  logic ovDetect;
  logic [1:0] irqEvents;
  logic [1:0] irqClear;

  // overvoltage held over the debounce lines, seen at a line start
  function automatic logic ov_hit(input logic sense, input logic line, input logic [1:0] cnt);
    return sense && line && (cnt == 2'(`DCDSX_OV_LINES - 1));
  endfunction

  // write strobe aimed at one register
  function automatic logic reg_write(input logic stb, input logic [3:0] a,
    input logic [3:0] target);
    return stb && (a == target);
  endfunction

  assign writeCtrl = reg_write(wrStb, addr, `DCDSX_ADDR_CTRL);
  assign writeIrq = reg_write(wrStb, addr, `DCDSX_ADDR_IRQ);
  assign alarmClear = lowSupply || (writeCtrl && wrData[`DCDSX_CTRL_CLR]);
  assign runWanted = ctrl[`DCDSX_CTRL_DRVEN] && !overvoltage_alarm_flag;
  assign lineOn = (phase != PH_OFF);
  assign convOn = (phase == PH_ALL);
  assign resetCond = currentTrip || regulationTrip;
  assign ovDetect = ov_hit(overvoltage_sense_in, lineStart, ovLines);
  // sticky sources: trip while latched, alarm detection
  assign irqEvents = {resetCond && latchOn, ovDetect};
  assign irqClear = writeIrq ? wrData[1:0] : 2'h0;

  // set source selection
  always_comb begin
    if (!ctrl[`DCDSX_CTRL_TRIGSRC]) begin
      setEvent = trigDelayRun && (trigDelayCnt == 8'h01);
    end else if (ctrl[`DCDSX_CTRL_EDGE]) begin
      setEvent = lineDriveRaw && !lineDrivePrev;
    end else begin
      setEvent = !lineDriveRaw && lineDrivePrev;
    end
  end

  // register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= `DCDSX_CTRL_RESET;
      vertical_jitter_amplitude <= `DCDSX_JITTER_RESET;
      irqMask <= 2'h0;
    end else if (wrStb) begin
      if (addr == `DCDSX_ADDR_CTRL) begin
        // alarm clear is a strobe, never stored
        ctrl <= wrData & ~(8'h01 << `DCDSX_CTRL_CLR);
      end
      if (addr == `DCDSX_ADDR_JITTER) begin
        vertical_jitter_amplitude <= wrData;
      end
      if (addr == `DCDSX_ADDR_MASK) begin
        irqMask <= wrData[1:0];
      end
    end
  end

  // read port
  always_ff @(posedge clk) begin
    if (srst) begin
      rdData <= 8'h00;
    end else if (rdStb) begin
      unique case (addr)
        `DCDSX_ADDR_CTRL: rdData <= ctrl;
        `DCDSX_ADDR_JITTER: rdData <= vertical_jitter_amplitude;
        `DCDSX_ADDR_STATUS: rdData <= {4'h0, phase, latchOn, overvoltage_alarm_flag};
        `DCDSX_ADDR_IRQ: rdData <= {6'h00, irqStatus};
        `DCDSX_ADDR_MASK: rdData <= {6'h00, irqMask};
        default: rdData <= 8'h00;
      endcase
    end else begin
      rdData <= 8'h00;
    end
  end

  // mid-flyback delay counter
  always_ff @(posedge clk) begin
    if (srst) begin
      trigDelayRun <= 1'b0;
      trigDelayCnt <= 8'h00;
      lineDrivePrev <= 1'b0;
    end else begin
      lineDrivePrev <= lineDriveRaw;
      if (flybackMid) begin
        trigDelayRun <= 1'b1;
        trigDelayCnt <= 8'(`DCDSX_TRIG_DELAY_CYC);
      end else if (trigDelayRun) begin
        trigDelayCnt <= trigDelayCnt - 8'h01;
        trigDelayRun <= (trigDelayCnt != 8'h01);
      end
    end
  end

  // monostable and drive latch
  always_ff @(posedge clk) begin
    if (srst) begin
      monoRun <= 1'b0;
      monoCnt <= 8'h00;
      latchOn <= 1'b0;
    end else if (resetCond || !convOn) begin
      monoRun <= 1'b0;
      latchOn <= 1'b0;
    end else if (setEvent) begin
      monoRun <= 1'b1;
      monoCnt <= 8'(`DCDSX_MONO_CYC);
    end else if (monoRun) begin
      monoCnt <= monoCnt - 8'h01;
      if (monoCnt == 8'h01) begin
        monoRun <= 1'b0;
        latchOn <= 1'b1;
      end
    end
  end

  // overvoltage debounce and alarm
  always_ff @(posedge clk) begin
    if (srst) begin
      ovLines <= 2'h0;
      overvoltage_alarm_flag <= 1'b0;
    end else begin
      if (!overvoltage_sense_in) begin
        ovLines <= 2'h0;
      end else if (lineStart && ovLines != 2'(`DCDSX_OV_LINES)) begin
        ovLines <= ovLines + 2'h1;
      end
      if (ovDetect) begin
        overvoltage_alarm_flag <= 1'b1;
      end else if (alarmClear) begin
        overvoltage_alarm_flag <= 1'b0;
      end
    end
  end

  // drive phasing sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= PH_OFF;
      phaseCnt <= 16'h0000;
    end else begin
      unique case (phase)
        PH_OFF: if (runWanted) begin
          phase <= PH_LINE;
          phaseCnt <= 16'(`DCDSX_PHASE_CYC);
        end
        PH_LINE: if (!runWanted) begin
          phase <= PH_OFF;
        end else if (phaseCnt == 16'h0001) begin
          phase <= PH_ALL;
        end else begin
          phaseCnt <= phaseCnt - 16'h0001;
        end
        PH_ALL: if (!runWanted) begin
          phase <= PH_STOP;
          phaseCnt <= 16'(`DCDSX_PHASE_CYC);
        end
        PH_STOP: if (phaseCnt == 16'h0001) begin
          phase <= PH_OFF;
        end else begin
          phaseCnt <= phaseCnt - 16'h0001;
        end
      endcase
    end
  end

  // drive outputs and option bits
  always_ff @(posedge clk) begin
    if (srst) begin
      converter_drive_out <= 1'b0;
      line_drive_out <= 1'b1;
      softRampActive <= 1'b0;
      sidepin_freq_tracking_enable <= 1'b0;
      dyn_correction_polarity <= 1'b0;
    end else begin
      converter_drive_out <= (latchOn && convOn && !resetCond && !overvoltage_alarm_flag)
        ^ ctrl[`DCDSX_CTRL_POL];
      line_drive_out <= (lineOn && !(overvoltage_alarm_flag && !convOn)) ? lineDriveRaw : 1'b1;
      softRampActive <= (phase == PH_LINE) || (phase == PH_STOP);
      sidepin_freq_tracking_enable <= ctrl[`DCDSX_CTRL_TRACK];
      dyn_correction_polarity <= ctrl[`DCDSX_CTRL_DYNPOL];
    end
  end

  // half frame rate offset
  always_ff @(posedge clk) begin
    if (srst) begin
      frameToggle <= 1'b0;
      verticalOffset <= 8'h00;
    end else begin
      if (frameStart) begin
        frameToggle <= !frameToggle;
      end
      verticalOffset <= frameToggle ? vertical_jitter_amplitude : 8'h00;
    end
  end

  // sticky interrupts
  always_ff @(posedge clk) begin
    if (srst) begin
      irqStatus <= 2'h0;
      irq <= 1'b0;
    end else begin
      // events win over a clear in the same cycle
      irqStatus <= (irqStatus & ~irqClear) | irqEvents;
      irq <= |(irqStatus & irqMask);
    end
  end
endmodule
`default_nettype wire

// file: hw/dcdsx_map.svh
// register offsets, fields, reset values and timing counts of the converter drive block
`ifndef DCDSX_MAP_SVH
`define DCDSX_MAP_SVH
`define DCDSX_ADDR_CTRL 4'h0
`define DCDSX_ADDR_JITTER 4'h1
`define DCDSX_ADDR_STATUS 4'h2
`define DCDSX_ADDR_IRQ 4'h3
`define DCDSX_ADDR_MASK 4'h4
`define DCDSX_CTRL_DRVEN 0
`define DCDSX_CTRL_TRIGSRC 1
`define DCDSX_CTRL_EDGE 2
`define DCDSX_CTRL_POL 3
`define DCDSX_CTRL_TRACK 4
`define DCDSX_CTRL_DYNPOL 5
`define DCDSX_CTRL_CLR 6
`define DCDSX_CTRL_RESET 8'h00
`define DCDSX_JITTER_RESET 8'h00
`define DCDSX_IRQ_ALARM 0
`define DCDSX_IRQ_TRIP 1
`define DCDSX_TRIG_DELAY_NS 100
`define DCDSX_CLK_PERIOD_NS 5
`define DCDSX_TRIG_DELAY_CYC ((`DCDSX_TRIG_DELAY_NS + `DCDSX_CLK_PERIOD_NS - 1) / `DCDSX_CLK_PERIOD_NS)
`define DCDSX_MONO_NS 50
`define DCDSX_MONO_CYC ((`DCDSX_MONO_NS + `DCDSX_CLK_PERIOD_NS - 1) / `DCDSX_CLK_PERIOD_NS)
`define DCDSX_PHASE_NS 1000
`define DCDSX_PHASE_CYC ((`DCDSX_PHASE_NS + `DCDSX_CLK_PERIOD_NS - 1) / `DCDSX_CLK_PERIOD_NS)
`define DCDSX_OV_LINES 2
`endif

// file: hw/dcdsx_pkg.sv
// types of the converter drive block
package dcdsx_pkg;
  typedef enum logic [1:0] {PH_OFF, PH_LINE, PH_ALL, PH_STOP} dcdsx_phase_e;
  typedef logic [7:0] dcdsx_word_t;
endpackage

// file: bench/dcdsx_props.sv
// port assertions of the converter drive block
`timescale 1ns/1ps
`default_nettype none
module dcdsx_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic currentTrip,
  input wire logic regulationTrip,
  input wire logic overvoltage_sense_in,
  input wire logic lowSupply,
  input wire logic lineStart,
  input wire logic frameStart,
  input wire logic converter_drive_out,
  input wire logic line_drive_out,
  input wire logic softRampActive,
  input wire logic sidepin_freq_tracking_enable,
  input wire logic dyn_correction_polarity,
  input wire logic [7:0] verticalOffset
);
  logic [7:0] ctl;
  logic [7:0] offCnt;
  logic [1:0] ovCnt;
  logic alm;
  logic polD;
  wire logic trip = currentTrip | regulationTrip;
  wire logic off = converter_drive_out == polD;
  wire logic wr0 = wrStb && addr == 4'h0;
  wire logic ov = overvoltage_sense_in;
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl <= 8'h00;
      offCnt <= 8'h00;
      ovCnt <= 2'h0;
      alm <= 1'b0;
      polD <= 1'b0;
    end else begin
      if (wr0) ctl <= wrData;
      polD <= ctl[3];
      offCnt <= ctl[0] ? 8'h00 : offCnt + {7'h00, offCnt != 8'hFF};
      ovCnt <= !ov ? 2'h0 : ovCnt + {1'b0, lineStart && ovCnt != 2'h2};
      if (ov && lineStart && ovCnt == 2'h1) alm <= 1'b1;
      else if (lowSupply || (wr0 && wrData[6])) alm <= 1'b0;
    end
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (srst);
  rst_vals_a: assert property (disable iff (1'b0) srst |=>
    !converter_drive_out && line_drive_out) else $error("reset levels");
  line_inhib_a: assert property (offCnt == 8'hFF |-> line_drive_out)
    else $error("line drive not inhibited");
  trip_off_a: assert property ((trip && $stable(ctl[3])) [*3] |-> off)
    else $error("trip left drive on");
  ramp_off_a: assert property (softRampActive [*2] |-> off)
    else $error("drive on during ramp");
  alarm_inhib_a: assert property (alm [*4] |-> line_drive_out && off)
    else $error("alarm did not inhibit");
  option_copy_a: assert property ($stable(ctl) [*3] |->
    sidepin_freq_tracking_enable == ctl[4] && dyn_correction_polarity == ctl[5])
    else $error("option bits differ");
  frame_toggle_a: assert property (frameStart && verticalOffset != 8'h00 |->
    ##2 verticalOffset == 8'h00) else $error("offset did not toggle");
endmodule
bind dcdsx_core dcdsx_props u_dcdsx_props (.*);
`default_nettype wire

// file: bench/dcdsx_stage.sv
// line timing and converter switch current model
`timescale 1ns/1ps
`default_nettype none
module dcdsx_stage #(
  parameter int LINE = 100,
  parameter int RAMP = 30
) (
  input wire logic clk,
  input wire logic swOn,
  output logic lineStart,
  output logic flybackMid,
  output logic lineDriveRaw,
  output logic frameStart,
  output logic currentTrip
);
  int cnt = 0;
  int ln = 0;
  int amp = 0;
  always_ff @(posedge clk) begin
    cnt <= (cnt == LINE - 1) ? 0 : cnt + 1;
    if (cnt == LINE - 1) ln <= (ln + 1) % 4;
    amp <= swOn ? amp + 1 : 0;
  end
  assign lineStart = cnt == 0;
  assign flybackMid = cnt == 5;
  assign lineDriveRaw = cnt < 50;
  assign frameStart = cnt == 0 && ln == 0;
  assign currentTrip = amp >= RAMP;
endmodule
`default_nettype wire

// file: bench/dcdsx_core_tb_top.sv
// self-checking bench of the converter drive block
`timescale 1ns/1ps
`default_nettype none
module dcdsx_core_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic regulationTrip = 1'b0;
  logic overvoltage_sense_in = 1'b0;
  logic lowSupply = 1'b0;
  logic [7:0] ctl = 8'h00;
  logic [7:0] v;
  logic [7:0] mode [4] = '{8'h01, 8'h05, 8'h07, 8'h03};
  int lat [4] = '{35, 35, 10, 60};
  int n_mismatch = 0;
  int n_tests = 0;
  int k;
  wire logic [7:0] rdData;
  wire logic [7:0] verticalOffset;
  wire logic flybackMid, lineDriveRaw, lineStart, frameStart, currentTrip, irq;
  wire logic converter_drive_out, line_drive_out, softRampActive;
  wire logic sidepin_freq_tracking_enable, dyn_correction_polarity;
  wire logic swOn = converter_drive_out ^ ctl[3];
  dcdsx_stage u_dcdsx_stage (.*);
  dcdsx_core u_dcdsx_core (.*);
  initial forever #2.5 clk = ~clk;
  task automatic close_out;
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    if (a == 4'h0) ctl = d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 chk(rdData & m, e);
  endtask
  task automatic line1;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (lineStart !== 1'b1 && k < 200);
    if (k == 200) begin
      n_mismatch++;
      close_out();
    end
  endtask
  task automatic mid;
    line1();
    repeat (55) @(negedge clk);
  endtask
  task automatic meas(input int e);
    line1();
    k = 0;
    while (swOn !== 1'b1 && k < 90) begin
      @(negedge clk);
      k++;
    end
    chk(8'(k >= e && k <= e + 4), 8'h01);
    if (k == 90) close_out();
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk({6'h00, line_drive_out, converter_drive_out}, 8'h02);
    rd(4'h0, 8'h00, 8'hFF);
    rd(4'hF, 8'h00, 8'hFF);
    wr(4'h0, 8'h01);
    repeat (3) @(negedge clk);
    chk(8'(softRampActive), 8'h01);
    repeat (3) line1();
    chk(8'(softRampActive), 8'h00);
    rd(4'h2, 8'h08, 8'hFF);
    foreach (mode[i]) begin
      wr(4'h0, mode[i]);
      meas(lat[i]);
    end
    rd(4'h3, 8'h02, 8'h02);
    @(posedge clk) regulationTrip <= 1'b1;
    line1();
    k = 0;
    repeat (100) @(negedge clk) k += swOn;
    chk(8'(k), 8'h00);
    wr(4'h0, 8'h0F);
    repeat (3) @(negedge clk);
    chk(8'(converter_drive_out), 8'h01);
    @(posedge clk) regulationTrip <= 1'b0;
    meas(10);
    @(posedge clk) overvoltage_sense_in <= 1'b1;
    mid();
    chk({6'h00, line_drive_out, swOn}, 8'h00);
    mid();
    chk({6'h00, line_drive_out, swOn}, 8'h02);
    chk(8'(irq), 8'h00);
    wr(4'h4, 8'h01);
    rd(4'h2, 8'h01, 8'h01);
    chk(8'(irq), 8'h01);
    @(posedge clk) overvoltage_sense_in <= 1'b0;
    mid();
    chk(8'(line_drive_out), 8'h01);
    wr(4'h3, 8'h01);
    repeat (3) @(negedge clk);
    chk(8'(irq), 8'h00);
    @(posedge clk) lowSupply <= 1'b1;
    @(posedge clk) lowSupply <= 1'b0;
    rd(4'h2, 8'h00, 8'h01);
    repeat (3) @(negedge clk);
    chk(8'(softRampActive), 8'h01);
    @(posedge clk) overvoltage_sense_in <= 1'b1;
    repeat (3) mid();
    @(posedge clk) overvoltage_sense_in <= 1'b0;
    wr(4'h0, 8'h4F);
    rd(4'h2, 8'h00, 8'h01);
    rd(4'h0, 8'h0F, 8'hFF);
    wr(4'h0, 8'h31);
    wr(4'h1, 8'h5A);
    repeat (3) @(negedge clk);
    chk({6'h00, sidepin_freq_tracking_enable, dyn_correction_polarity}, 8'h03);
    mid();
    v = verticalOffset;
    repeat (4) mid();
    chk(v ^ verticalOffset, 8'h5A);
    wr(4'h0, 8'h00);
    repeat (3) mid();
    chk(8'(line_drive_out), 8'h01);
    close_out();
  end
endmodule
`default_nettype wire
